// *** design/cba_arbiter.sv ***
// configuration bus arbiter with calibration status registers
`timescale 1ns/100ps
module cba_arbiter #(
  parameter bit SEPARATE_WAIT = 1'b0,
  parameter bit MERGED_SIMPLEX = 1'b0,
  parameter int CAL_CYCLES = cba_pkg::CAL_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // reconfiguration port
  input  wire logic [10:0] reconfig_address,
  input  wire logic        reconfig_write,
  input  wire logic        reconfig_read,
  input  wire logic [7:0]  reconfig_writedata,
  output logic [7:0]       reconfig_readdata,
  output logic             reconfig_waitrequest,
  // calibration status
  output logic             tx_cal_busy,
  output logic             rx_cal_busy,
  output logic             pll_cal_busy
);
  // ==========================================================
  // state
  cba_pkg::cba_owner_e owner_q;
  logic [7:0] calen_q;
  logic [1:0] busyen_q;
  logic [1:0] arm_q;
  logic       pwrup_q;
  logic       cal_busy;
  logic       cal_done;
  logic       abort;
  logic       start_d;
  logic       wr_own;
  logic       wr_user;
  logic       lane_busy_q [2];

  // ==========================================================
  // refuse settings the counters cannot serve
  if (CAL_CYCLES < 1 || CAL_CYCLES > 65535) begin : g_bad_cycles
    $error("CAL_CYCLES out of range");
  end
  if (cba_pkg::BUSY_DELAY < 1 || cba_pkg::BUSY_DELAY > 2) begin : g_bad_delay
    $error("BUSY_DELAY does not fit the arm shifter");
  end

  // ==========================================================
  // decode helpers
  function automatic logic hit(input logic [10:0] a, input logic [10:0] o);
    return a == o;
  endfunction

  // any lane asks for a recalibration
  function automatic logic cal_wanted(input logic [7:0] en);
    return en[cba_pkg::CALEN_RX_BIT] || en[cba_pkg::CALEN_TX_BIT];
  endfunction

  // channel capability word, busy bits gated like the pins
  function automatic logic [7:0] chcap_word(input logic       eng,
                                            input logic       busy,
                                            input logic [1:0] en);
    logic [7:0] w;
    w = 8'h00;
    w[cba_pkg::CAP_RXBUSY_BIT] = busy && en[0];
    w[cba_pkg::CAP_TXBUSY_BIT] = busy && en[1];
    w[cba_pkg::CAP_OWNER_BIT] = eng;
    w[cba_pkg::CAP_RXEN_BIT] = en[0];
    w[cba_pkg::CAP_TXEN_BIT] = en[1];
    return w;
  endfunction

  // pll capability word, busy never gated
  function automatic logic [7:0] pllcap_word(input logic eng,
                                             input logic busy);
    logic [7:0] w;
    w = 8'h00;
    w[cba_pkg::CAP_RXBUSY_BIT] = busy;
    w[cba_pkg::CAP_OWNER_BIT] = eng;
    return w;
  endfunction

  // ownership control word, bit one is inverted busy
  function automatic logic [7:0] ctrl_word(input logic eng,
                                           input logic busy);
    logic [7:0] w;
    w = 8'h00;
    w[cba_pkg::OWN_BIT] = eng;
    w[cba_pkg::DONE_BIT] = !busy;
    return w;
  endfunction

  // capability reads need no arbitration; others only when granted
  assign wr_user = reconfig_write && owner_q == cba_pkg::CBA_USER;
  assign wr_own = reconfig_write && hit(reconfig_address,
                                        cba_pkg::OFS_OWNER);
  assign abort = wr_own && cal_busy
                 && reconfig_writedata[1:0] == 2'h2;
  assign start_d = arm_q[cba_pkg::BUSY_DELAY-1];

  cba_cal_engine #(.CYCLES(CAL_CYCLES)) u_eng (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .start   (start_d),
    .abort   (abort),
    .busy    (cal_busy),
    .done    (cal_done)
  );

  // ==========================================================
  // ownership and calibration launch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      owner_q <= cba_pkg::CBA_ENGINE;
      pwrup_q <= 1'b1;
      arm_q <= 2'h0;
    end else if (clk_en) begin
      arm_q <= {arm_q[0], 1'b0};
      if (pwrup_q) begin
        pwrup_q <= 1'b0;
        arm_q <= 2'h1;
      end else if (abort) begin
        owner_q <= cba_pkg::CBA_USER;
      end else if (cal_done) begin
        owner_q <= cba_pkg::CBA_USER;
      end else if (wr_own) begin
        // engine owner accepts a write of 0 to bit zero while cal_busy is low, or while busy with bit one set, as the abort above
        if (!reconfig_writedata[cba_pkg::OWN_BIT]) begin
          if (!cal_busy) owner_q <= cba_pkg::CBA_USER;
        end else begin
          owner_q <= cba_pkg::CBA_ENGINE;
          if (!reconfig_writedata[cba_pkg::DONE_BIT]
              && cal_wanted(calen_q))
            arm_q <= 2'h1;
          else if (reconfig_writedata[cba_pkg::DONE_BIT]
                   && !cal_wanted(calen_q))
            owner_q <= cba_pkg::CBA_USER;
        end
      end
    end
  end

  // ==========================================================
  // enable registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      calen_q <= cba_pkg::CALEN_RST;
      busyen_q <= cba_pkg::BUSYEN_RST;
    end else if (clk_en) begin
      if (wr_user && hit(reconfig_address, cba_pkg::OFS_CALEN))
        calen_q <= reconfig_writedata;
      if (reconfig_write && hit(reconfig_address, cba_pkg::OFS_CHCAP)
          && !MERGED_SIMPLEX)
        busyen_q <= {reconfig_writedata[cba_pkg::CAP_TXEN_BIT],
                     reconfig_writedata[cba_pkg::CAP_RXEN_BIT]};
    end
  end

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reconfig_waitrequest <= !SEPARATE_WAIT;
      reconfig_readdata <= 8'h00;
      pll_cal_busy <= 1'b0;
    end else if (clk_en) begin
      reconfig_waitrequest <= !SEPARATE_WAIT
                              && owner_q == cba_pkg::CBA_ENGINE;
      pll_cal_busy <= cal_busy;
      reconfig_readdata <= 8'h00;
      if (reconfig_read) begin
        if (hit(reconfig_address, cba_pkg::OFS_CHCAP))
          reconfig_readdata <= chcap_word(owner_q == cba_pkg::CBA_ENGINE,
                                          cal_busy, busyen_q);
        else if (hit(reconfig_address, cba_pkg::OFS_PLLCAP))
          reconfig_readdata <= pllcap_word(owner_q == cba_pkg::CBA_ENGINE,
                                           cal_busy);
        else if (owner_q == cba_pkg::CBA_USER) begin
          if (hit(reconfig_address, cba_pkg::OFS_OWNER))
            reconfig_readdata <= ctrl_word(1'b0, cal_busy);
          else if (hit(reconfig_address, cba_pkg::OFS_CALEN))
            reconfig_readdata <= calen_q;
        end
      end
    end
  end

  // ==========================================================
  // per-lane busy gating, one flop per lane
  generate
    for (genvar g = 0; g < 2; g++) begin : g_lane
      always_ff @(posedge clk) begin
        if (!reset_n)
          lane_busy_q[g] <= 1'b0;
        else if (clk_en)
          lane_busy_q[g] <= cal_busy && busyen_q[g];
      end
    end
  endgenerate

  // rx is lane 0 and tx lane 1, as in the enable bits
  assign rx_cal_busy = lane_busy_q[0];
  assign tx_cal_busy = lane_busy_q[1];
endmodule

// *** design/cba_pkg.sv ***
// constants for the configuration bus arbitration block
package cba_pkg;
  // ==========================================================
  // register offsets
  localparam logic [10:0] OFS_OWNER = 11'h000;
  localparam logic [10:0] OFS_CALEN = 11'h100;
  localparam logic [10:0] OFS_PLLCAP = 11'h480;
  localparam logic [10:0] OFS_CHCAP = 11'h481;
  // ==========================================================
  // field positions
  localparam int OWN_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int CAP_OWNER_BIT = 2;
  localparam int CAP_RXEN_BIT = 4;
  localparam int CAP_TXEN_BIT = 5;
  localparam int CAP_RXBUSY_BIT = 0;
  localparam int CAP_TXBUSY_BIT = 1;
  localparam int CALEN_RX_BIT = 0;
  localparam int CALEN_TX_BIT = 1;
  // ==========================================================
  // reset values and timing
  localparam logic [7:0] CALEN_RST = 8'h03;
  localparam logic [1:0] BUSYEN_RST = 2'h3;
  localparam int BUSY_DELAY = 2;
  localparam int CAL_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  // ==========================================================
  // owner of the internal bus
  typedef enum logic {CBA_USER, CBA_ENGINE} cba_owner_e;
endpackage

// *** design/cba_cal_engine.sv ***
// calibration engine sequencer model
`timescale 1ns/100ps
module cba_cal_engine #(
  parameter int CYCLES = cba_pkg::CAL_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      done
);
  // ==========================================================
  // cycle counter
  logic [15:0] cnt_q;

  initial begin
    if (CYCLES < 1 || CYCLES > 65535) $error("bad CYCLES");
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
        cnt_q <= 16'h0000;
      end else if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= 16'(CYCLES);
      end else if (busy) begin
        if (cnt_q == 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule

// *** sim/cba_arbiter_checker.sv ***
// assertion checker for the bus arbiter
`timescale 1ns/100ps
module cba_arbiter_checker (
  input wire logic        clk, reset_n, clk_en,
  input wire logic        reconfig_write, reconfig_read,
  input wire logic [10:0] reconfig_address,
  input wire logic [7:0]  reconfig_writedata, reconfig_readdata,
  input wire logic        reconfig_waitrequest,
  input wire logic        tx_cal_busy, rx_cal_busy, pll_cal_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire own_wr = reconfig_write && clk_en && reconfig_address == 11'h000;
  a_tx_node: assert property (tx_cal_busy |-> pll_cal_busy)
    else $error("tx busy alone");
  a_wait_engine: assert property (
    pll_cal_busy |-> reconfig_waitrequest)
    else $error("wait low in calibration");
  a_read_idle: assert property (
    !$past(reconfig_read) |-> reconfig_readdata == 8'h00)
    else $error("stray read data");
  a_owner_bit: assert property (
    reconfig_read && reconfig_address == 11'h481 && pll_cal_busy
    ##1 pll_cal_busy |-> reconfig_readdata[2])
    else $error("owner bit low");
  a_start_busy: assert property (
    own_wr && reconfig_writedata == 8'h01 && !pll_cal_busy
    && !reconfig_waitrequest |-> ##[3:4] pll_cal_busy)
    else $error("busy late");
  a_busy_hold: assert property ($rose(pll_cal_busy) |-> pll_cal_busy[*8])
    else $error("busy short");
  a_abort_cal: assert property (
    own_wr && reconfig_writedata[1:0] == 2'h2 && pll_cal_busy
    |-> ##[1:6] !pll_cal_busy)
    else $error("abort ignored");
  a_user_back: assert property (
    $fell(pll_cal_busy) |-> ##[0:3] !reconfig_waitrequest)
    else $error("wait stuck high");
endmodule
bind cba_arbiter cba_arbiter_checker cba_arbiter_checker_i (.*);

// *** sim/cba_user_master.sv ***
// user reconfiguration master model
`timescale 1ns/100ps
module cba_user_master (
  input  wire logic       clk,
  output logic [10:0]     address,
  output logic            write,
  output logic            read,
  output logic [7:0]      writedata,
  input  wire logic [7:0] readdata
);
  initial begin
    {address, write, read, writedata} = {11'h7FF, 2'h0, 8'hFF};
  end
  // one-cycle strobe; idle lines turned over so stale values never match
  task automatic acc(input logic w, input logic [10:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {address, writedata, write, read} = {a, d, w, !w};
    @(negedge clk);
    {address, writedata, write, read} = {~a, ~d, 2'h0};
    q = readdata;
  endtask
endmodule

// *** sim/test_cba_arbiter.sv ***
// testbench for the configuration bus arbiter
`timescale 1ns/100ps
module test_cba_arbiter;
  logic clk = 1'b0, reset_n = 1'b0, wq, txb, rxb, pllb, w, r;
  logic [10:0] a;
  logic [7:0] wd, rd, q;
  int errors = 0, comparisons = 0;
  initial forever #25 clk = ~clk;
  cba_arbiter #(.CAL_CYCLES(20)) cba_arbiter_i (.clk(clk),
    .reset_n(reset_n), .clk_en(1'b1), .reconfig_address(a),
    .reconfig_write(w), .reconfig_read(r), .reconfig_writedata(wd),
    .reconfig_readdata(rd), .reconfig_waitrequest(wq),
    .tx_cal_busy(txb), .rx_cal_busy(rxb), .pll_cal_busy(pllb));
  cba_user_master cba_user_master_i (.clk(clk), .address(a), .write(w),
    .read(r), .writedata(wd), .readdata(rd));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [10:0] ad, logic [7:0] d);
    cba_user_master_i.acc(1'b1, ad, d, q);
  endtask
  task automatic rdc(logic [10:0] ad, logic [7:0] e);
    cba_user_master_i.acc(1'b0, ad, 8'h00, q);
    chk("readdata", e, q);
  endtask
  // status nibble: wait, tx, rx, pll
  task automatic st(logic [3:0] e);
    chk("status", {4'h0, e}, {4'h0, wq, txb, rxb, pllb});
  endtask
  task automatic wait_user;
    for (int i = 0; i < 60 && wq !== 1'b0; i++) @(negedge clk);
    if (wq !== 1'b0) begin errors++; end_of_test(); end
  endtask
  task automatic t_power;
    repeat (6) @(negedge clk);
    st(4'hF);
    rdc(11'h481, 8'h37);
    rdc(11'h480, 8'h05);
    rdc(11'h000, 8'h00);
    wait_user();
    st(4'h0);
    rdc(11'h481, 8'h30);
    rdc(11'h100, 8'h03);
    $display("test power done");
  endtask
  task automatic t_recal;
    wr(11'h100, 8'h01);
    wr(11'h000, 8'h01);
    repeat (5) @(negedge clk);
    st(4'hF);
    wait_user();
    rdc(11'h000, 8'h02);
    $display("test recal done");
  endtask
  task automatic t_gate;
    wr(11'h481, 8'h20);
    wr(11'h000, 8'h01);
    repeat (5) @(negedge clk);
    st(4'hD);
    rdc(11'h481, 8'h26);
    wait_user();
    wr(11'h481, 8'h30);
    $display("test gate done");
  endtask
  task automatic t_abort;
    wr(11'h000, 8'h01);
    repeat (12) @(negedge clk);
    wr(11'h000, 8'h02);
    wait_user();
    st(4'h0);
    $display("test abort done");
  endtask
  task automatic t_nocal;
    wr(11'h100, 8'h00);
    wr(11'h000, 8'h03);
    repeat (4) @(negedge clk);
    st(4'h0);
    rdc(11'h100, 8'h00);
    $display("test nocal done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    t_power();
    t_recal();
    t_gate();
    t_abort();
    t_nocal();
    end_of_test();
  end
endmodule
